/* adc_host_pkg.sv */
// Constants, carrier type and states for the converter host controller.
// Assumes a 25 MHz controller clock; acquisition and timeout counts are derived from it.
package adc_host_pkg;
	localparam int CLK_NS = 40;
	localparam int CONV_FAST_NS = 1470;
	localparam int CONV_SLOW_NS = 1600;
	localparam int ACQ_FAST_NS = 200;
	localparam int ACQ_SLOW_NS = 400;
	localparam int DONE_PULSE_NS = 100;
	localparam int RES_W = 12;
	localparam int LEAD_ZEROS = 4;
	localparam int SER_BITS = LEAD_ZEROS + RES_W;
	localparam int SYNC_W = RES_W + 5;
	localparam logic [7:0] ACQ_FAST_CYC = 8'((ACQ_FAST_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] ACQ_SLOW_CYC = 8'((ACQ_SLOW_NS + CLK_NS - 1) / CLK_NS);
	// Timeout is twice the slow conversion time plus the done pulse
	localparam logic [7:0] CONV_TIMEOUT_CYC =
		8'((2 * CONV_SLOW_NS + DONE_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] START_LOW_CYC = 8'h02;
	localparam logic [7:0] READ_LOW_CYC = 8'h04;
	localparam logic [7:0] SCLK_HALF_CYC = 8'h04;
	localparam logic [4:0] SER_BITS_CNT = 5'(SER_BITS);

	typedef struct packed {
		logic [RES_W-1:0] code;
		logic twos_comp;
		logic timed_out;
	} sample_s;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START_LOW, ST_CONVERT, ST_PAR_READ, ST_FRAME, ST_SHIFT, ST_ACQUIRE
	} state_e;
endpackage

/* adc_host.sv */
// Host controller that starts conversions on a 12-bit sampling converter and
// reads each result over the parallel bus or the three-wire serial link.
// Assumes device pins arrive asynchronously; the serial clock is made here.
// Functional notes
// RQ1: A rising edge on convert_start_n puts the converter in hold and starts conversion.
// RQ2: Falling conversion-done edge ends conversion; acquisition begins there.
// RQ3: Fast grade converts within 1.47 us and needs 200 ns acquisition.
// RQ4: Slow grades convert in 1.6 us and need 400 ns acquisition.
// RQ5: Next start edge waits a full acquisition after end of conversion.
// RQ6: Strap high selects parallel readout, low selects serial readout.
// RQ7: Conversion-done pulses low when a fresh result is in the output register.
// RQ8: Parallel result is driven only while select and read are both low.
// RQ9: Read strobe falls at least 200 ns before the next start edge.
// RQ10: Custom logic may wire conversion-done straight to select and read.
// RQ11: Select and read should not be held low permanently.
// RQ12: Host drives serial clock and frame_sync_n, pulling frame sync low to read.
// RQ13: Serial clock may gap, but frame_sync_n stays low for the whole transfer.
// RQ14: Serial word is four zeros then the 12-bit result, MSB first.
// RQ15: Device shifts each serial bit out on the rising serial clock edge.
// RQ16: Slow serial clocks let the host capture on the falling edge.
// RQ17: With rising-edge capture, frame sync must not fall just before a rise.
// RQ18: Serial output three-states on the first rise of clock or frame sync.
// RQ19: Serial reads happen only between end of conversion and next start.
// RQ20: Serial reads stay 200 ns or 400 ns clear of the start edge.
// RQ21: Conversion-done low pulse lasts about 100 ns.
// RQ22: Codes are two's complement on bipolar grades, straight binary on unipolar.
// RQ23: In serial mode frame_sync_n shares the pin of result bus bit 3.
// RQ24: The result stays unchanged until the next conversion completes.
`timescale 1ns/10ps
`default_nettype none
module adc_host
	import adc_host_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start_req,
	output logic ready,
	output sample_s sample,
	output logic sample_valid,
	input wire logic parallel_mode,
	input wire logic fast_grade,
	input wire logic unipolar,
	output logic convert_start_n,
	input wire logic conv_done_n,
	output logic chip_select_n,
	output logic read_n,
	input wire logic [RES_W-1:0] result_bus_in,
	output logic frame_sync_n,
	output logic frame_sync_oe,
	output logic sclk,
	input wire logic serial_out
);
	state_e state;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic done_prev;
	logic [7:0] cnt;
	logic [4:0] bits;
	logic [RES_W-1:0] shreg;
	logic par;
	logic fast;
	logic uni;

	// Pin inputs pass two flops; only sync2 is ever read by logic
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// Idle level of every pin, so no false done edge follows reset
			sync1 <= '1;
			sync2 <= '1;
			done_prev <= 1'b1;
		end else begin
			sync1 <= {conv_done_n, serial_out, parallel_mode, fast_grade, unipolar, result_bus_in};
			sync2 <= sync1;
			done_prev <= sync2[SYNC_W-1];
		end
	end

	wire done_s = sync2[SYNC_W-1];
	wire serial_out_s = sync2[SYNC_W-2];
	wire par_s = sync2[SYNC_W-3];
	wire fast_s = sync2[SYNC_W-4];
	wire uni_s = sync2[SYNC_W-5];
	wire [RES_W-1:0] bus_s = sync2[RES_W-1:0];
	// The done pulse (about 100 ns) spans at least two clock samples
	wire done_fall = done_prev & ~done_s; // RQ2 RQ7 RQ21
	wire [7:0] acq_cyc = fast ? ACQ_FAST_CYC : ACQ_SLOW_CYC; // RQ3 RQ4
	wire cnt_end = (cnt == 8'h01);
	wire last_bit = (bits == SER_BITS_CNT);

	// One place builds a published word, so both readouts mark coding alike
	// and a good read always clears a stale timeout mark
	function automatic sample_s publish(input logic [RES_W-1:0] word, input logic straight);
		publish = '{code: word, twos_comp: ~straight, timed_out: 1'b0};
	endfunction

	assign ready = (state == ST_IDLE);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			cnt <= 8'h00;
			bits <= 5'h00;
			shreg <= '0;
			par <= 1'b1;
			fast <= 1'b0;
			uni <= 1'b0;
			sample <= '0;
			sample_valid <= 1'b0;
			convert_start_n <= 1'b1;
			chip_select_n <= 1'b1;
			read_n <= 1'b1;
			frame_sync_n <= 1'b1;
			frame_sync_oe <= 1'b0;
			sclk <= 1'b0;
		end else begin
			sample_valid <= 1'b0;
			// Bit-3 pin turns around one cycle after the mode latch
			frame_sync_oe <= ~par; // RQ6 RQ23
			case (state)
			ST_IDLE: begin
				if (start_req) begin
					par <= par_s; // RQ6
					fast <= fast_s;
					uni <= uni_s;
					convert_start_n <= 1'b0;
					cnt <= START_LOW_CYC;
					state <= ST_START_LOW;
				end
			end
			ST_START_LOW: begin
				if (cnt_end) begin
					convert_start_n <= 1'b1; // RQ1
					cnt <= CONV_TIMEOUT_CYC;
					state <= ST_CONVERT;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_CONVERT: begin
				// Reads start only after conversion is done, never during it
				if (done_fall) begin // RQ19
					if (par) begin
						// Strobes follow the synchronised done edge, not the raw pulse
						chip_select_n <= 1'b0; // RQ8 RQ10 RQ11
						read_n <= 1'b0;
						cnt <= READ_LOW_CYC;
						state <= ST_PAR_READ;
					end else begin
						frame_sync_n <= 1'b0; // RQ12
						bits <= 5'h00;
						cnt <= SCLK_HALF_CYC; // RQ17
						state <= ST_FRAME;
					end
				end else if (cnt_end) begin
					// No done edge: the old code stays, only the mark is set
					sample.timed_out <= 1'b1;
					sample_valid <= 1'b1;
					cnt <= acq_cyc;
					state <= ST_ACQUIRE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_PAR_READ: begin
				// Strobe held long enough for the bus to pass the synchroniser
				if (cnt_end) begin
					sample <= publish(bus_s, uni); // RQ22 RQ24
					sample_valid <= 1'b1;
					chip_select_n <= 1'b1; // RQ11
					read_n <= 1'b1;
					cnt <= acq_cyc; // RQ9
					state <= ST_ACQUIRE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_FRAME: begin
				if (cnt_end) begin
					sclk <= 1'b1; // RQ15
					cnt <= SCLK_HALF_CYC;
					state <= ST_SHIFT;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			ST_SHIFT: begin
				if (!cnt_end) begin
					cnt <= cnt - 8'h01;
				end else if (sclk) begin
					// Capture on the falling edge; the bit settled after the rise
					sclk <= 1'b0; // RQ16
					shreg <= {shreg[RES_W-2:0], serial_out_s}; // RQ14
					bits <= bits + 5'h01;
					cnt <= SCLK_HALF_CYC;
				end else if (last_bit) begin
					// Frame sync held low across all bits, rising ends the frame
					frame_sync_n <= 1'b1; // RQ13 RQ18
					sample <= publish(shreg, uni); // RQ22 RQ24
					sample_valid <= 1'b1;
					cnt <= acq_cyc; // RQ20
					state <= ST_ACQUIRE;
				end else begin
					sclk <= 1'b1; // RQ15
					cnt <= SCLK_HALF_CYC;
				end
			end
			ST_ACQUIRE: begin
				// Acquisition is timed from after the read, so it also covers EOC
				if (cnt_end) begin // RQ5
					state <= ST_IDLE;
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* adc_host_sva.sv */
// Checker for the converter host controller.
// Bound into adc_host; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module adc_host_sva
	import adc_host_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start_req,
	input wire logic ready,
	input wire sample_s sample,
	input wire logic sample_valid,
	input wire logic convert_start_n,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic frame_sync_n,
	input wire logic sclk
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_START_TAKEN: assert property ($fell(convert_start_n) |-> $past(ready && start_req))
		else $error("start");
	AST_START_WIDTH: assert property ($fell(convert_start_n) |-> ##1 !convert_start_n ##1 convert_start_n)
		else $error("start width");
	AST_READ_WIDTH: assert property ($fell(read_n) |-> (!read_n && !chip_select_n)[*4] ##1 read_n)
		else $error("read");
	AST_ACQ_GAP: assert property ($rose(read_n) || $rose(frame_sync_n) |-> convert_start_n[*5])
		else $error("gap");
	AST_PUBLISH: assert property ($rose(read_n) || $rose(frame_sync_n) |-> sample_valid)
		else $error("publish");
	AST_CLK_IN_FRAME: assert property (frame_sync_n |-> !sclk)
		else $error("sclk");
	AST_FS_LEAD: assert property ($fell(frame_sync_n) |-> !sclk[*4] ##1 sclk)
		else $error("lead");
	AST_SAMPLE_HOLD: assert property ($changed(sample) |-> sample_valid)
		else $error("hold");
	cover property ($fell(read_n));
	cover property ($fell(frame_sync_n));
	cover property (sample_valid && sample.timed_out);
endmodule
bind adc_host adc_host_sva u_adc_host_sva (.mclk, .arst_n, .start_req, .ready, .sample,
	.sample_valid, .convert_start_n, .chip_select_n, .read_n, .frame_sync_n, .sclk);
`default_nettype wire

/* adc_dev_model.sv */
// Behavioural converter on the far side of the host pins.
// The bench resolves the shared bit-3 pin into fs_n.
`timescale 1ns/10ps
`default_nettype none
module adc_dev_model
	import adc_host_pkg::*;
(
	input wire logic mode,
	input wire logic fast,
	input wire logic hang,
	input wire logic [RES_W-1:0] code,
	input wire logic conv_n,
	output logic done_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic fs_n,
	input wire logic sck,
	output logic [RES_W-1:0] bus,
	output logic sdo
);
	logic [RES_W-1:0] out_reg = '0;
	int n = 0;
	logic armed = 1'b0;
	// Released lines show the inverse so a stale value cannot pass
	assign bus = (mode && !cs_n && !rd_n) ? out_reg : ~out_reg;
	initial done_n = 1'b1;
	initial sdo = 1'b0;
	// Only a low-then-high start counts; the pin settling at power-up does not
	always @(negedge conv_n) armed = 1'b1;
	always @(posedge conv_n) if (armed) begin
		armed = 1'b0;
		#(fast ? CONV_FAST_NS : CONV_SLOW_NS);
		if (!hang) begin
			out_reg = code;
			done_n = 1'b0;
			#(DONE_PULSE_NS) done_n = 1'b1;
		end
	end
	always @(negedge fs_n) n = 0;
	always @(posedge sck or posedge fs_n) begin
		if (!mode && !fs_n && sck && n < SER_BITS) begin
			sdo = (n < LEAD_ZEROS) ? 1'b0 : out_reg[SER_BITS-1-n];
			n++;
		end else sdo = ~sdo;
	end
endmodule
`default_nettype wire

/* test_adc_host.sv */
// Self-checking bench for the converter host controller.
// Drives the user port at falling edges; the model answers the pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("Error %s exp %h got %h", nm, e, a); end end
module test_adc_host
	import adc_host_pkg::*;
;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic start_req = 1'b0;
	logic pm = 1'b1, fg = 1'b1, un = 1'b0, hang = 1'b0;
	logic [RES_W-1:0] code = '0;
	logic ready, sample_valid, conv_n, done_n, cs_n, rd_n, fs_n, fs_oe, sclk, sdo;
	logic [RES_W-1:0] dev_bus, pin;
	sample_s sample;
	int n_errors = 0;
	int compares = 0;
	assign pin = fs_oe ? {dev_bus[11:4], fs_n, dev_bus[2:0]} : dev_bus;
	adc_host u_adc_host (.mclk, .arst_n, .start_req, .ready, .sample, .sample_valid,
		.parallel_mode(pm), .fast_grade(fg), .unipolar(un), .convert_start_n(conv_n),
		.conv_done_n(done_n), .chip_select_n(cs_n), .read_n(rd_n), .result_bus_in(pin),
		.frame_sync_n(fs_n), .frame_sync_oe(fs_oe), .sclk, .serial_out(sdo));
	adc_dev_model u_adc_dev_model (.mode(pm), .fast(fg), .hang, .code, .conv_n, .done_n,
		.cs_n, .rd_n, .fs_n(pin[3]), .sck(sclk), .bus(dev_bus), .sdo);
	initial forever #20 mclk = ~mclk;
	task automatic print_verdict;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic run(input logic p, f, u, h, input logic [RES_W-1:0] c);
		int i;
		int j;
		{pm, fg, un, hang, code} = {p, f, u, h, c};
		repeat (4) @(negedge mclk);
		for (i = 0; i < 500 && ready !== 1'b1; i++) @(negedge mclk);
		start_req = 1'b1;
		@(negedge mclk);
		start_req = 1'b0;
		for (j = 0; j < 500 && sample_valid !== 1'b1; j++) @(negedge mclk);
		if (i == 500 || j == 500) begin
			n_errors++;
			print_verdict();
		end
		// Acquisition wait, counted from the publish to the return of ready
		for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge mclk);
		`CHK("acq", int'(f ? ACQ_FAST_CYC : ACQ_SLOW_CYC), i)
	endtask
	task automatic test_parallel;
		run(1'b1, 1'b1, 1'b0, 1'b0, 12'hA5C);
		`CHK("code", 12'hA5C, sample.code)
		`CHK("twos", 1'b1, sample.twos_comp)
		`CHK("fs_oe", 1'b0, fs_oe)
		$display("parallel done");
	endtask
	task automatic test_serial;
		run(1'b0, 1'b0, 1'b1, 1'b0, 12'h3C9);
		`CHK("code", 12'h3C9, sample.code)
		`CHK("twos", 1'b0, sample.twos_comp)
		`CHK("fs_oe", 1'b1, fs_oe)
		$display("serial done");
	endtask
	task automatic test_timeout;
		run(1'b1, 1'b1, 1'b0, 1'b1, 12'h5A3);
		`CHK("tmo", 1'b1, sample.timed_out)
		`CHK("code", 12'h3C9, sample.code)
		$display("timeout done");
	endtask
	initial begin
		repeat (5) @(negedge mclk);
		arst_n = 1'b1;
		test_parallel();
		test_serial();
		test_timeout();
		print_verdict();
	end
endmodule
`default_nettype wire
